//--- rtl/prf_request_flags.sv
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

`include "prf_consts.svh"

// Behaviour
// - pending flags clear only on a written 0; a written 1 leaves them alone.
// - core accepting a request never clears its pending flag.
// - timer/pin flags reset to 0x10; bit 4 reads 1, bit 5 reads 0.
// - bit 7 sets when the second timer wraps from FF to 00.
// - bit 6 sets when the first timer wraps from FF to 00.
// - bits 3..0 set on the chosen edge of a pin in request function.
// - each request pin has its own rising or falling polarity bit.
// - peripheral flags reset to 0x00; bit 5 and bits 3..0 read 0.
// - bit 7 sets on sleep direct transfer while direct transfer is on.
// - bit 6 sets when conversion ends and the start flag drops to 0.
// - bit 4 sets when the first serial unit completes a transfer.
// - eight edge-pin flags reset to 0; flag n sets on pin n's edge.
// - each edge pin has its own rising or falling polarity bit.
// - a request pin is not recognised while its enable bit is 0.
// - an edge pin is not recognised while its enable bit is 0.
// - global mask blocks external requests; acceptance sets the mask.
// - request pins 3..0 use vectors 7..4; pin 0 has top priority.
// - all edge pins share vector 8; software reads flags to find source.
// - edge-pin flags set on edges even when the pin serves as a port.
// - polarity 0 selects falling, 1 rising; polarity resets to falling.
// - pick highest-priority enabled flag; accept only when mask is 0.
// - a clear colliding with a request while unmasked is taken afterwards.
module prf_request_flags
  import prf_pkg::*;
#(
  parameter int REQ_PINS = 4,
  parameter int EDGE_PINS = 8
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire prf_pkg::prf_addr_t addr,
  input wire prf_pkg::prf_byte_t wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output prf_pkg::prf_byte_t rdata,
  input wire logic [REQ_PINS-1:0] request_pins,
  input wire logic [EDGE_PINS-1:0] edge_pins,
  input wire logic first_timer_wrap,
  input wire logic second_timer_wrap,
  input wire logic sleep_direct_transfer,
  input wire logic direct_transfer_on,
  input wire logic conversion_end,
  input wire logic conversion_start_flag,
  input wire logic serial_done,
  input wire logic irq_ack,
  output logic irq_req,
  output prf_pkg::prf_vec_t irq_vector,
  output logic global_mask
);

  import prf_pkg::*;

  // ----------------------------------------------------------------
  // reset state
  // ----------------------------------------------------------------
  localparam prf_ctl_st_t RESET_ST = '{
    timer_pin_req_flags: `PRF_TIMER_PIN_RST,
    peripheral_req_flags: `PRF_PERIPH_RST,
    edge_pin_req_flags: `PRF_EDGE_PIN_RST,
    first_enable_reg: `PRF_FIRST_EN_RST,
    second_enable_reg: `PRF_SECOND_EN_RST,
    third_enable_reg: `PRF_BYTE_ZERO,
    request_pin_polarity_reg: `PRF_NIBBLE_ZERO,
    edge_pin_polarity_reg: `PRF_BYTE_ZERO,
    port_mode_reg: `PRF_NIBBLE_ZERO,
    global_mask: `PRF_MASK_RST,
    irq_req: 1'b0,
    irq_vector: `PRF_VEC_NONE,
    rdata: `PRF_BYTE_ZERO
  };

  // ----------------------------------------------------------------
  // registered state and edge pulses
  // ----------------------------------------------------------------
  prf_ctl_st_t st_reg;
  prf_ctl_st_t st_next;

  logic [REQ_PINS-1:0] req_edge;
  logic [EDGE_PINS-1:0] pin_edge;

  // ----------------------------------------------------------------
  // per-pin edge sensing
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < REQ_PINS; gi++) begin : g_req
      // port mode gating is applied at the flag, not here
      prf_edge_sense u_sense (
        .clk(clk),
        .rst_n(rst_n),
        .pin(request_pins[gi]),
        .rise_sel(st_reg.request_pin_polarity_reg[gi]),
        .pulse(req_edge[gi])
      );
    end
    for (gi = 0; gi < EDGE_PINS; gi++) begin : g_edge
      // sensed regardless of port use of the pin
      prf_edge_sense u_sense (
        .clk(clk),
        .rst_n(rst_n),
        .pin(edge_pins[gi]),
        .rise_sel(st_reg.edge_pin_polarity_reg[gi]),
        .pulse(pin_edge[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic wr_tp;
    logic wr_pf;
    logic wr_ep;
    prf_byte_t tp_set;
    prf_byte_t pf_set;
    prf_byte_t tp_keep;
    prf_byte_t pf_keep;
    prf_byte_t ep_keep;
    prf_byte_t tp_live;
    prf_byte_t pf_live;
    prf_byte_t ep_live;
    logic found;
    prf_vec_t vec;

    wr_tp = 1'b0;
    wr_pf = 1'b0;
    wr_ep = 1'b0;
    tp_set = `PRF_BYTE_ZERO;
    pf_set = `PRF_BYTE_ZERO;
    tp_keep = `PRF_BYTE_ONES;
    pf_keep = `PRF_BYTE_ONES;
    ep_keep = `PRF_BYTE_ONES;
    tp_live = `PRF_BYTE_ZERO;
    pf_live = `PRF_BYTE_ZERO;
    ep_live = `PRF_BYTE_ZERO;
    found = 1'b0;
    vec = `PRF_VEC_NONE;
    st_next = st_reg;

    // --------------------------------------------------------------
    // flag register write decode
    // --------------------------------------------------------------
    wr_tp = wr_en && (addr == `PRF_OFS_TIMER_PIN_FLAGS);
    wr_pf = wr_en && (addr == `PRF_OFS_PERIPH_FLAGS);
    wr_ep = wr_en && (addr == `PRF_OFS_EDGE_PIN_FLAGS);

    // --------------------------------------------------------------
    // set sources
    // --------------------------------------------------------------
    tp_set[`PRF_BIT_SECOND_TIMER] = second_timer_wrap;
    tp_set[`PRF_BIT_FIRST_TIMER] = first_timer_wrap;
    // request pins count only while in request function
    tp_set[REQ_PINS-1:0] = req_edge & st_reg.port_mode_reg;
    pf_set[`PRF_BIT_DIRECT] = sleep_direct_transfer & direct_transfer_on;
    pf_set[`PRF_BIT_CONVERSION] = conversion_end & ~conversion_start_flag;
    pf_set[`PRF_BIT_SERIAL] = serial_done;

    // --------------------------------------------------------------
    // flag registers: a written 0 clears, a written 1 keeps
    // --------------------------------------------------------------
    if (wr_tp) begin
      tp_keep = wdata;
    end
    if (wr_pf) begin
      pf_keep = wdata;
    end
    if (wr_ep) begin
      ep_keep = wdata;
    end
    // set ORed in after the clear so a coincident event survives
    st_next.timer_pin_req_flags =
      (((st_reg.timer_pin_req_flags & tp_keep) | tp_set) & `PRF_TIMER_PIN_WMASK)
      | `PRF_TIMER_PIN_FIXED;
    st_next.peripheral_req_flags =
      ((st_reg.peripheral_req_flags & pf_keep) | pf_set) & `PRF_PERIPH_WMASK;
    // edge pins latch whatever the pin is used for
    st_next.edge_pin_req_flags =
      (st_reg.edge_pin_req_flags & ep_keep) | pin_edge;

    // --------------------------------------------------------------
    // control registers
    // --------------------------------------------------------------
    if (wr_en) begin
      unique case (addr)
        `PRF_OFS_FIRST_ENABLE: begin
          // bit 4 is forced back to 1 on every write
          st_next.first_enable_reg = (wdata & `PRF_FIRST_EN_WMASK) | `PRF_FIRST_EN_FIXED;
        end
        `PRF_OFS_SECOND_ENABLE: begin
          st_next.second_enable_reg = wdata & `PRF_SECOND_EN_WMASK;
        end
        `PRF_OFS_THIRD_ENABLE: begin
          st_next.third_enable_reg = wdata;
        end
        `PRF_OFS_REQ_POLARITY: begin
          st_next.request_pin_polarity_reg = wdata[3:0];
        end
        `PRF_OFS_EDGE_POLARITY: begin
          st_next.edge_pin_polarity_reg = wdata;
        end
        `PRF_OFS_PORT_MODE: begin
          st_next.port_mode_reg = wdata[3:0];
        end
        `PRF_OFS_GLOBAL_MASK: begin
          st_next.global_mask = wdata[0];
        end
        default: begin
        end
      endcase
    end

    // --------------------------------------------------------------
    // recognition and priority
    // --------------------------------------------------------------
    // enables gate recognition only; flags keep latching
    tp_live = st_reg.timer_pin_req_flags & st_reg.first_enable_reg
              & `PRF_TIMER_PIN_WMASK;
    pf_live = st_reg.peripheral_req_flags & st_reg.second_enable_reg;
    ep_live = st_reg.edge_pin_req_flags & st_reg.third_enable_reg;

    // --------------------------------------------------------------
    // priority: request pins, edge pins, then internal sources
    // --------------------------------------------------------------
    // pin 0 highest; pin n takes vector base + n
    for (int i = REQ_PINS - 1; i >= 0; i--) begin
      if (tp_live[i]) begin
        found = 1'b1;
        vec = `PRF_VEC_REQ_PIN_BASE + prf_vec_t'(i);
      end
    end
    if (!found && (ep_live != `PRF_BYTE_ZERO)) begin
      found = 1'b1;
      vec = `PRF_VEC_EDGE_PINS;
    end
    // internal sources in a fixed order after the shared edge vector
    if (!found && pf_live[`PRF_BIT_DIRECT]) begin
      found = 1'b1;
      vec = `PRF_VEC_DIRECT;
    end
    if (!found && tp_live[`PRF_BIT_FIRST_TIMER]) begin
      found = 1'b1;
      vec = `PRF_VEC_FIRST_TIMER;
    end
    if (!found && tp_live[`PRF_BIT_SECOND_TIMER]) begin
      found = 1'b1;
      vec = `PRF_VEC_SECOND_TIMER;
    end
    if (!found && pf_live[`PRF_BIT_SERIAL]) begin
      found = 1'b1;
      vec = `PRF_VEC_SERIAL;
    end
    if (!found && pf_live[`PRF_BIT_CONVERSION]) begin
      found = 1'b1;
      vec = `PRF_VEC_CONVERSION;
    end

    // --------------------------------------------------------------
    // acceptance: flags untouched, mask set, request withdrawn
    // --------------------------------------------------------------
    if (irq_ack && st_reg.irq_req) begin
      st_next.global_mask = 1'b1;
    end
    // request follows the flags, so a flag cleared before acceptance
    // withdraws it on the next edge
    st_next.irq_req = found & ~st_next.global_mask;
    // vector stays while its flag stands, even once accepted
    st_next.irq_vector = found ? vec : `PRF_VEC_NONE;

    // --------------------------------------------------------------
    // read path, data valid in the cycle after the strobe
    // --------------------------------------------------------------
    // zero outside the read slot
    st_next.rdata = `PRF_BYTE_ZERO;
    if (rd_en) begin
      unique case (addr)
        `PRF_OFS_TIMER_PIN_FLAGS: begin
          st_next.rdata = st_reg.timer_pin_req_flags;
        end
        `PRF_OFS_PERIPH_FLAGS: begin
          st_next.rdata = st_reg.peripheral_req_flags;
        end
        `PRF_OFS_EDGE_PIN_FLAGS: begin
          st_next.rdata = st_reg.edge_pin_req_flags;
        end
        `PRF_OFS_FIRST_ENABLE: begin
          st_next.rdata = st_reg.first_enable_reg;
        end
        `PRF_OFS_SECOND_ENABLE: begin
          st_next.rdata = st_reg.second_enable_reg;
        end
        `PRF_OFS_THIRD_ENABLE: begin
          st_next.rdata = st_reg.third_enable_reg;
        end
        `PRF_OFS_REQ_POLARITY: begin
          st_next.rdata = {4'h0, st_reg.request_pin_polarity_reg};
        end
        `PRF_OFS_EDGE_POLARITY: begin
          st_next.rdata = st_reg.edge_pin_polarity_reg;
        end
        `PRF_OFS_PORT_MODE: begin
          st_next.rdata = {4'h0, st_reg.port_mode_reg};
        end
        `PRF_OFS_GLOBAL_MASK: begin
          st_next.rdata = {7'h00, st_reg.global_mask};
        end
        `PRF_OFS_VECTOR: begin
          st_next.rdata = {st_reg.irq_req, 2'h0, st_reg.irq_vector};
        end
        default: begin
          st_next.rdata = `PRF_BYTE_ZERO;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= RESET_ST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every output is a field of the state register
  assign rdata = st_reg.rdata;
  assign irq_req = st_reg.irq_req;
  assign irq_vector = st_reg.irq_vector;
  assign global_mask = st_reg.global_mask;

endmodule

`default_nettype wire

//--- rtl/prf_consts.svh
`ifndef PRF_CONSTS_SVH
`define PRF_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PRF_OFS_TIMER_PIN_FLAGS 4'h0
`define PRF_OFS_PERIPH_FLAGS 4'h1
`define PRF_OFS_EDGE_PIN_FLAGS 4'h2
`define PRF_OFS_FIRST_ENABLE 4'h3
`define PRF_OFS_SECOND_ENABLE 4'h4
`define PRF_OFS_THIRD_ENABLE 4'h5
`define PRF_OFS_REQ_POLARITY 4'h6
`define PRF_OFS_EDGE_POLARITY 4'h7
`define PRF_OFS_PORT_MODE 4'h8
`define PRF_OFS_GLOBAL_MASK 4'h9
`define PRF_OFS_VECTOR 4'hA

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PRF_BIT_SECOND_TIMER 7
`define PRF_BIT_FIRST_TIMER 6
`define PRF_BIT_DIRECT 7
`define PRF_BIT_CONVERSION 6
`define PRF_BIT_SERIAL 4

// ----------------------------------------------------------------
// reset values, writable masks, fixed bits
// ----------------------------------------------------------------
`define PRF_TIMER_PIN_RST 8'h10
`define PRF_TIMER_PIN_FIXED 8'h10
`define PRF_TIMER_PIN_WMASK 8'hCF
`define PRF_PERIPH_RST 8'h00
`define PRF_PERIPH_WMASK 8'hD0
`define PRF_EDGE_PIN_RST 8'h00
`define PRF_FIRST_EN_RST 8'h10
`define PRF_FIRST_EN_FIXED 8'h10
`define PRF_FIRST_EN_WMASK 8'hCF
`define PRF_SECOND_EN_RST 8'h00
`define PRF_SECOND_EN_WMASK 8'hD0
`define PRF_BYTE_ZERO 8'h00
`define PRF_BYTE_ONES 8'hFF
`define PRF_NIBBLE_ZERO 4'h0
`define PRF_MASK_RST 1'b1

// ----------------------------------------------------------------
// vector numbers
// ----------------------------------------------------------------
`define PRF_VEC_REQ_PIN_BASE 5'h04
`define PRF_VEC_EDGE_PINS 5'h08
`define PRF_VEC_DIRECT 5'h09
`define PRF_VEC_FIRST_TIMER 5'h0B
`define PRF_VEC_SECOND_TIMER 5'h0D
`define PRF_VEC_SERIAL 5'h12
`define PRF_VEC_CONVERSION 5'h13
`define PRF_VEC_NONE 5'h00

`endif

//--- rtl/prf_pkg.sv
package prf_pkg;

  typedef logic [7:0] prf_byte_t;
  typedef logic [3:0] prf_addr_t;
  typedef logic [4:0] prf_vec_t;

  // edge sensing state of one pin
  typedef struct packed {
    logic sync_a;
    logic sync_b;
    logic last;
    logic pulse;
  } prf_edge_st_t;

  // whole state of the request flag block
  typedef struct packed {
    prf_byte_t timer_pin_req_flags;
    prf_byte_t peripheral_req_flags;
    prf_byte_t edge_pin_req_flags;
    prf_byte_t first_enable_reg;
    prf_byte_t second_enable_reg;
    prf_byte_t third_enable_reg;
    logic [3:0] request_pin_polarity_reg;
    prf_byte_t edge_pin_polarity_reg;
    logic [3:0] port_mode_reg;
    logic global_mask;
    logic irq_req;
    prf_vec_t irq_vector;
    prf_byte_t rdata;
  } prf_ctl_st_t;

endpackage

//--- rtl/prf_edge_sense.sv
`timescale 1ns/1ps
`default_nettype none

module prf_edge_sense
  import prf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  input wire logic rise_sel,
  output logic pulse
);

  import prf_pkg::*;

  prf_edge_st_t st_reg;
  prf_edge_st_t st_next;

  // ----------------------------------------------------------------
  // two-stage synchroniser and edge compare
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.sync_a = pin;
    st_next.sync_b = st_reg.sync_a;
    st_next.last = st_reg.sync_b;
    // polarity 1 rising, 0 falling
    st_next.pulse = rise_sel ? (st_reg.sync_b & ~st_reg.last)
                             : (~st_reg.sync_b & st_reg.last);
  end

  // pins idle high, so reset high to avoid a false rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{sync_a: 1'b1, sync_b: 1'b1, last: 1'b1, pulse: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign pulse = st_reg.pulse;

endmodule

`default_nettype wire

//--- sim/prf_request_flags_asserts.sv
`timescale 1ns/1ps
`default_nettype none

`include "prf_consts.svh"

module prf_request_flags_chk
  import prf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire prf_pkg::prf_addr_t addr,
  input wire prf_pkg::prf_byte_t wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire prf_pkg::prf_byte_t rdata,
  input wire logic irq_ack,
  input wire logic irq_req,
  input wire prf_pkg::prf_vec_t irq_vector,
  input wire logic global_mask
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_ack_masks;
    irq_ack && irq_req |=> global_mask && !irq_req;
  endproperty
  a_ack_masks: assert property (p_ack_masks)
    else $error("accepted request left mask clear");
  property p_mask_rise;
    $rose(global_mask) |-> $past(irq_ack && irq_req) || $past(wr_en && addr == 4'h9);
  endproperty
  a_mask_rise: assert property (p_mask_rise)
    else $error("mask set without cause");
  property p_mask_fall;
    $fell(global_mask) |-> $past(wr_en && addr == 4'h9 && !wdata[0]);
  endproperty
  a_mask_fall: assert property (p_mask_fall)
    else $error("mask cleared without a write");
  property p_masked_idle;
    global_mask |-> !irq_req;
  endproperty
  a_masked_idle: assert property (p_masked_idle)
    else $error("request raised while masked");
  property p_vec_set;
    irq_req |-> irq_vector inside {5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0B, 5'h0D,
      5'h12, 5'h13};
  endproperty
  a_vec_set: assert property (p_vec_set)
    else $error("request with unknown vector");
  property p_fixed0;
    rd_en && addr == 4'h0 |=> rdata[5:4] == 2'b01;
  endproperty
  a_fixed0: assert property (p_fixed0)
    else $error("fixed timer flag bits wrong");
  property p_fixed1;
    rd_en && addr == 4'h1 |=> (rdata & 8'h2F) == 8'h00;
  endproperty
  a_fixed1: assert property (p_fixed1)
    else $error("reserved peripheral flag bits set");
  property p_no_self_clear;
    rd_en && addr == 4'h2 ##1 !wr_en ##1 rd_en && addr == 4'h2
      |=> (rdata & $past(rdata, 2)) == $past(rdata, 2);
  endproperty
  a_no_self_clear: assert property (p_no_self_clear)
    else $error("edge flag cleared without a write");
  property p_rd_idle;
    !rd_en |=> rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");

  c_ack: cover property (irq_ack && irq_req);
  c_edge_vec: cover property (irq_req && irq_vector == 5'h08);
  c_pin_vec: cover property (irq_req && irq_vector == 5'h04);
endmodule

bind prf_request_flags prf_request_flags_chk chk_i (.clk(clk), .rst_n(rst_n), .addr(addr),
  .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq_ack(irq_ack),
  .irq_req(irq_req), .irq_vector(irq_vector), .global_mask(global_mask));

`default_nettype wire

//--- sim/prf_far_model.sv
`timescale 1ns/1ps
`default_nettype none

module prf_far_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] ev,
  input wire logic ack_en,
  input wire logic [1:0] lat,
  input wire logic irq_req,
  output logic first_timer_wrap,
  output logic second_timer_wrap,
  output logic sleep_direct_transfer,
  output logic conversion_end,
  output logic serial_done,
  output logic irq_ack
);
  logic [2:0] wait_reg;

  // peripherals pulse one cycle on command; core accepts after lat cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {serial_done, conversion_end, sleep_direct_transfer} <= 3'h0;
      {second_timer_wrap, first_timer_wrap, irq_ack} <= 3'h0;
      wait_reg <= 3'h0;
    end else begin
      {serial_done, conversion_end, sleep_direct_transfer} <= ev[4:2];
      {second_timer_wrap, first_timer_wrap} <= ev[1:0];
      irq_ack <= 1'b0;
      wait_reg <= 3'h0;
      if (irq_req && ack_en && !irq_ack) begin
        if (wait_reg >= {1'b0, lat}) begin
          irq_ack <= 1'b1;
        end else begin
          wait_reg <= wait_reg + 3'h1;
        end
      end
    end
  end
endmodule

`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  import prf_pkg::*;
  logic clk, rst_n, wr_en, rd_en, dto, csf, ack_en, rd_q;
  logic ftw, stw, sdt, ce, sd, ack, irq, gm;
  logic [3:0] rp, p1;
  logic [7:0] ep, p2, ex;
  logic [4:0] ev;
  logic [1:0] lat;
  logic [31:0] rs;
  prf_addr_t addr;
  prf_byte_t wdata, rdata;
  prf_vec_t vec;
  prf_byte_t q[$];
  prf_byte_t rv[12] = '{8'h10, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h01, 8'h00, 8'h00};
  int n_errors, samples_checked, cyc;

  prf_request_flags DUT (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .request_pins(rp), .edge_pins(ep),
    .first_timer_wrap(ftw), .second_timer_wrap(stw), .sleep_direct_transfer(sdt),
    .direct_transfer_on(dto), .conversion_end(ce), .conversion_start_flag(csf),
    .serial_done(sd), .irq_ack(ack), .irq_req(irq), .irq_vector(vec), .global_mask(gm));
  prf_far_model far (.clk(clk), .rst_n(rst_n), .ev(ev), .ack_en(ack_en), .lat(lat),
    .irq_req(irq), .first_timer_wrap(ftw), .second_timer_wrap(stw),
    .sleep_direct_transfer(sdt), .conversion_end(ce), .serial_done(sd), .irq_ack(ack));

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic chk(input string nm, input prf_byte_t e, input prf_byte_t s);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic chk_mask(input logic e, input logic s);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value global_mask expected %b seen %b", e, s);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input prf_addr_t a, input prf_byte_t d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    step(1);
    wr_en <= 1'b0;
    step(1);
  endtask

  task automatic rd(input prf_addr_t a, input prf_byte_t e);
    q.push_back(e);
    addr <= a;
    rd_en <= 1'b1;
    step(1);
    rd_en <= 1'b0;
    step(1);
  endtask

  task automatic fire(input logic [4:0] b);
    ev <= b;
    step(1);
    ev <= 5'h00;
    step(1);
  endtask

  task automatic report_and_stop();
    $display("checked %0d mismatched %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // read monitor: result stands the cycle after the strobe
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rd_q <= rd_en;
    if (rd_q)
      chk("rdata", q.pop_front(), rdata);
    if (cyc == 3000) begin
      n_errors++;
      report_and_stop();
    end
  end

  initial begin
    rst_n = 1'b0;
    {wr_en, rd_en, dto, csf, ack_en} = 5'h00;
    addr = 4'h0;
    wdata = 8'h00;
    rp = 4'hF;
    ep = 8'hFF;
    ev = 5'h00;
    lat = 2'h0;
    rs = 32'h7935;
    step(6);
    rst_n <= 1'b1;
    step(1);
    foreach (rv[i]) rd(prf_addr_t'(i), rv[i]);
    chk_mask(1'b1, gm);
    $display("done reset values");
    dto <= 1'b1;
    for (int i = 0; i < 5; i++) fire(5'h01 << i);
    rd(4'h0, 8'hD0);
    rd(4'h1, 8'hD0);
    wr(4'h1, 8'h00);
    dto <= 1'b0;
    csf <= 1'b1;
    fire(5'h04);
    fire(5'h08);
    rd(4'h1, 8'h00);
    wr(4'h0, 8'hFF);
    rd(4'h0, 8'hD0);
    rs = xs(rs);
    wr(4'h0, rs[7:0]);
    rd(4'h0, (8'hD0 & rs[7:0]) | 8'h10);
    ev <= 5'h02;
    step(1);
    ev <= 5'h00;
    wr(4'h0, 8'h00);
    rd(4'h0, 8'h90);
    wr(4'h0, 8'h00);
    $display("done events");
    p1 = rs[11:8];
    wr(4'h6, {4'h0, p1});
    rp <= ~p1;
    step(6);
    rp <= p1;
    step(6);
    rd(4'h0, 8'h10);
    wr(4'h8, 8'h0F);
    rp <= ~p1;
    step(6);
    rp <= p1;
    step(6);
    rd(4'h0, 8'h1F);
    wr(4'h9, 8'h00);
    rd(4'hA, 8'h00);
    wr(4'h3, 8'h04);
    rd(4'hA, 8'h86);
    wr(4'h3, 8'h0F);
    rd(4'hA, 8'h84);
    wr(4'h9, 8'h01);
    rd(4'hA, 8'h04);
    wr(4'h0, 8'hFE);
    rd(4'hA, 8'h05);
    wr(4'h0, 8'h00);
    $display("done request pins");
    p2 = rs[23:16];
    wr(4'h7, p2);
    ep <= ~p2;
    step(6);
    ep <= p2;
    step(6);
    rd(4'h2, 8'hFF);
    rd(4'h2, 8'hFF);
    wr(4'h9, 8'h00);
    rd(4'hA, 8'h00);
    wr(4'h5, 8'h20);
    rd(4'hA, 8'h88);
    $display("done edge pins");
    lat <= rs[25:24];
    ack_en <= 1'b1;
    step(8);
    chk_mask(1'b1, gm);
    rd(4'hA, 8'h08);
    rd(4'h2, 8'hFF);
    ack_en <= 1'b0;
    $display("done acceptance");
    ex = 8'hFF;
    repeat (4) begin
      rs = xs(rs);
      wr(4'h2, rs[7:0]);
      ex = ex & rs[7:0];
      rd(4'h2, ex);
    end
    $display("done random clears");
    step(2);
    report_and_stop();
  end
endmodule

`default_nettype wire
